// file: verilog/tlic_pkg.sv
// package of constants for the two level interrupt controller
//------------------------------------------------------------
// Notes on behaviour
//------------------------------------------------------------
package tlic_pkg;
  //------------------------------------------------------------
  // register addresses and reset values
  //------------------------------------------------------------
  localparam logic [7:0] IRQ_ENABLE_ADDR = 8'hA8;
  localparam logic [7:0] SEC_EN_PRI_ADDR = 8'hA9;
  localparam logic [7:0] IRQ_PRIORITY_ADDR = 8'hB8;
  localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
  localparam logic [7:0] SEC_EN_PRI_RESET = 8'hA0;
  localparam logic [7:0] IRQ_PRIORITY_RESET = 8'h00;
  localparam logic [7:0] IRQ_PRIORITY_MASK = 8'h7F;
  localparam logic [7:0] SEC_EN_PRI_MASK = 8'h77;
  localparam logic [7:0] SEC_EN_PRI_RSVD_SET = 8'h80;
  localparam int GLOBAL_GATE_BIT = 7;
  // field positions shared by primary enable and priority
  localparam int ADC_BIT = 6;
  localparam int TIMER2_BIT = 5;
  localparam int UART_BIT = 4;
  localparam int TIMER1_BIT = 3;
  localparam int EXT1_BIT = 2;
  localparam int TIMER0_BIT = 1;
  localparam int EXT0_BIT = 0;
  // secondary register field positions
  localparam int INTERVAL_LEVEL_BIT = 6;
  localparam int SUPPLY_MON_LEVEL_BIT = 5;
  localparam int SPI_LEVEL_BIT = 4;
  localparam int INTERVAL_ON_BIT = 2;
  localparam int SUPPLY_MON_ON_BIT = 1;
  localparam int SPI_ON_BIT = 0;
  //------------------------------------------------------------
  // sources in polling order, index 0 polled first
  //------------------------------------------------------------
  localparam int NUM_SRC = 11;
  localparam int SRC_SUPPLY = 0;
  localparam int SRC_WDOG = 1;
  localparam int SRC_EXT0 = 2;
  localparam int SRC_ADC = 3;
  localparam int SRC_TIMER0 = 4;
  localparam int SRC_EXT1 = 5;
  localparam int SRC_TIMER1 = 6;
  localparam int SRC_SPI = 7;
  localparam int SRC_UART = 8;
  localparam int SRC_TIMER2 = 9;
  localparam int SRC_INTERVAL = 10;
  localparam logic [15:0] VEC_EXT0 = 16'h0003;
  localparam logic [15:0] VEC_TIMER0 = 16'h000B;
  localparam logic [15:0] VEC_EXT1 = 16'h0013;
  localparam logic [15:0] VEC_TIMER1 = 16'h001B;
  localparam logic [15:0] VEC_UART = 16'h0023;
  localparam logic [15:0] VEC_TIMER2 = 16'h002B;
  localparam logic [15:0] VEC_ADC = 16'h0033;
  localparam logic [15:0] VEC_SPI = 16'h003B;
  localparam logic [15:0] VEC_SUPPLY = 16'h0043;
  localparam logic [15:0] VEC_INTERVAL = 16'h0053;
  localparam logic [15:0] VEC_WDOG = 16'h005B;
  typedef enum logic [1:0] {
    TLIC_IDLE = 2'b00,
    TLIC_SAVE = 2'b01,
    TLIC_VECTOR = 2'b10
  } tlic_state_e;
endpackage : tlic_pkg

// file: verilog/tlic_poll.sv
// fixed order first-set picker over one priority level
`timescale 1ns/10ps
module tlic_poll (
  input wire logic [10:0] req_i,
  output logic found_o,
  output logic [3:0] index_o
);
  always_comb begin
    found_o = 1'b0;
    index_o = 4'h0;
    for (int i = tlic_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        found_o = 1'b1;
        index_o = 4'(i);
      end
    end
  end
endmodule : tlic_poll

// file: verilog/tlic_top.sv
// two level interrupt controller with special-function registers
`timescale 1ns/10ps
module tlic_top (
  input wire logic clock_i,
  input wire logic rstn_i,
  // special-function register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  output logic sfr_hit_o,
  // source flags, level held by the peripherals
  input wire logic supply_mon_flag_i,
  input wire logic watchdog_flag_i,
  input wire logic watchdog_irq_select_i,
  input wire logic [3:0] watchdog_timeout_i,
  input wire logic ext0_flag_i,
  input wire logic adc_done_a_i,
  input wire logic adc_done_b_i,
  input wire logic timer0_overflow_i,
  input wire logic ext1_flag_i,
  input wire logic timer1_overflow_i,
  input wire logic spi_done_flag_i,
  input wire logic rx_done_flag_i,
  input wire logic tx_done_flag_i,
  input wire logic timer2_overflow_i,
  input wire logic timer2_ext_flag_i,
  input wire logic interval_flag_i,
  // core handshake
  input wire logic core_ready_i,
  input wire logic pc_saved_i,
  input wire logic reti_i,
  output logic irq_req_o,
  output logic pc_save_o,
  output logic vector_valid_o,
  output logic [15:0] vector_o,
  output logic [3:0] src_o,
  output logic active_high_o,
  output logic active_low_o
);
  //------------------------------------------------------------
  // handshake overview
  //------------------------------------------------------------
  // irq_req_o is a level: some enabled request could be taken now
  // a grant is taken only in idle with core_ready_i high
  // pc_save_o then stands until the core reports pc_saved_i
  // vector_valid_o is one cycle; vector_o and src_o hold until the next grant
  // reti_i releases the innermost level, high before low

  //------------------------------------------------------------
  // registers
  //------------------------------------------------------------
  logic [7:0] irq_enable_reg;
  logic [7:0] secondary_enable_priority_reg;
  logic [7:0] irq_priority_reg;
  logic wr_enable;
  logic wr_secondary;
  logic wr_priority;
  logic [7:0] prio_wdata;
  logic [7:0] sec_wdata;

  assign wr_enable = sfr_wr_i && (sfr_addr_i == tlic_pkg::IRQ_ENABLE_ADDR);
  assign wr_secondary = sfr_wr_i && (sfr_addr_i == tlic_pkg::SEC_EN_PRI_ADDR);
  assign wr_priority = sfr_wr_i && (sfr_addr_i == tlic_pkg::IRQ_PRIORITY_ADDR);

  // reserved bits are shaped on the way in, so a read always shows the fixed values
  assign prio_wdata = sfr_wdata_i & tlic_pkg::IRQ_PRIORITY_MASK;
  // secondary bit 7 reads as one and bit 3 as zero, whatever software wrote
  assign sec_wdata = (sfr_wdata_i & tlic_pkg::SEC_EN_PRI_MASK) | tlic_pkg::SEC_EN_PRI_RSVD_SET;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_enable_reg <= tlic_pkg::IRQ_ENABLE_RESET;
    end else if (wr_enable) begin
      irq_enable_reg <= sfr_wdata_i;
    end
  end

  // priority register, bit 7 reads zero
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_priority_reg <= tlic_pkg::IRQ_PRIORITY_RESET;
    end else if (wr_priority) begin
      irq_priority_reg <= prio_wdata;
    end
  end

  // bit 3 is dropped, so a stray one from software does no harm
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      secondary_enable_priority_reg <= tlic_pkg::SEC_EN_PRI_RESET;
    end else if (wr_secondary) begin
      secondary_enable_priority_reg <= sec_wdata;
    end
  end

  // read data is registered; unmapped reads answer zero with hit low
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sfr_rdata_o <= 8'h00;
      sfr_hit_o <= 1'b0;
    end else if (sfr_rd_i) begin
      unique case (sfr_addr_i)
        tlic_pkg::IRQ_ENABLE_ADDR: begin
          sfr_rdata_o <= irq_enable_reg;
          sfr_hit_o <= 1'b1;
        end
        tlic_pkg::SEC_EN_PRI_ADDR: begin
          sfr_rdata_o <= secondary_enable_priority_reg;
          sfr_hit_o <= 1'b1;
        end
        tlic_pkg::IRQ_PRIORITY_ADDR: begin
          sfr_rdata_o <= irq_priority_reg;
          sfr_hit_o <= 1'b1;
        end
        default: begin
          sfr_rdata_o <= 8'h00;
          sfr_hit_o <= 1'b0;
        end
      endcase
    end else begin
      sfr_hit_o <= 1'b0;
    end
  end

  //------------------------------------------------------------
  // request gathering
  //------------------------------------------------------------
  logic [10:0] raw_req;
  logic [10:0] src_on;
  logic [10:0] src_high;
  logic [10:0] req_high;
  logic [10:0] req_low;
  logic global_gate;
  logic wdog_req;
  logic wdog_timeout_set;

  assign global_gate = irq_enable_reg[tlic_pkg::GLOBAL_GATE_BIT];
  // a zero timeout setting never raises the watchdog request
  assign wdog_timeout_set = (watchdog_timeout_i != 4'h0);
  // only interrupt mode turns a timeout into a request
  assign wdog_req = watchdog_flag_i && watchdog_irq_select_i && wdog_timeout_set;

  // flags are levels held by the peripherals; clearing them is their job
  // shared sources combine their flags
  always_comb begin
    raw_req = 11'h000;
    raw_req[tlic_pkg::SRC_SUPPLY] = supply_mon_flag_i;
    raw_req[tlic_pkg::SRC_WDOG] = wdog_req;
    raw_req[tlic_pkg::SRC_EXT0] = ext0_flag_i;
    raw_req[tlic_pkg::SRC_ADC] = adc_done_a_i | adc_done_b_i;
    raw_req[tlic_pkg::SRC_TIMER0] = timer0_overflow_i;
    raw_req[tlic_pkg::SRC_EXT1] = ext1_flag_i;
    raw_req[tlic_pkg::SRC_TIMER1] = timer1_overflow_i;
    raw_req[tlic_pkg::SRC_SPI] = spi_done_flag_i;
    raw_req[tlic_pkg::SRC_UART] = rx_done_flag_i | tx_done_flag_i;
    raw_req[tlic_pkg::SRC_TIMER2] = timer2_overflow_i | timer2_ext_flag_i;
    raw_req[tlic_pkg::SRC_INTERVAL] = interval_flag_i;
  end

  always_comb begin
    src_on = 11'h000;
    src_high = 11'h000;
    src_on[tlic_pkg::SRC_SUPPLY] = global_gate && secondary_enable_priority_reg[tlic_pkg::SUPPLY_MON_ON_BIT];
    src_on[tlic_pkg::SRC_WDOG] = 1'b1;
    src_on[tlic_pkg::SRC_EXT0] = global_gate && irq_enable_reg[tlic_pkg::EXT0_BIT];
    src_on[tlic_pkg::SRC_ADC] = global_gate && irq_enable_reg[tlic_pkg::ADC_BIT];
    src_on[tlic_pkg::SRC_TIMER0] = global_gate && irq_enable_reg[tlic_pkg::TIMER0_BIT];
    src_on[tlic_pkg::SRC_EXT1] = global_gate && irq_enable_reg[tlic_pkg::EXT1_BIT];
    src_on[tlic_pkg::SRC_TIMER1] = global_gate && irq_enable_reg[tlic_pkg::TIMER1_BIT];
    src_on[tlic_pkg::SRC_SPI] = global_gate && secondary_enable_priority_reg[tlic_pkg::SPI_ON_BIT];
    src_on[tlic_pkg::SRC_UART] = global_gate && irq_enable_reg[tlic_pkg::UART_BIT];
    src_on[tlic_pkg::SRC_TIMER2] = global_gate && irq_enable_reg[tlic_pkg::TIMER2_BIT];
    src_on[tlic_pkg::SRC_INTERVAL] = global_gate && secondary_enable_priority_reg[tlic_pkg::INTERVAL_ON_BIT];
    src_high[tlic_pkg::SRC_SUPPLY] = secondary_enable_priority_reg[tlic_pkg::SUPPLY_MON_LEVEL_BIT];
    src_high[tlic_pkg::SRC_WDOG] = 1'b1;
    src_high[tlic_pkg::SRC_EXT0] = irq_priority_reg[tlic_pkg::EXT0_BIT];
    src_high[tlic_pkg::SRC_ADC] = irq_priority_reg[tlic_pkg::ADC_BIT];
    src_high[tlic_pkg::SRC_TIMER0] = irq_priority_reg[tlic_pkg::TIMER0_BIT];
    src_high[tlic_pkg::SRC_EXT1] = irq_priority_reg[tlic_pkg::EXT1_BIT];
    src_high[tlic_pkg::SRC_TIMER1] = irq_priority_reg[tlic_pkg::TIMER1_BIT];
    src_high[tlic_pkg::SRC_SPI] = secondary_enable_priority_reg[tlic_pkg::SPI_LEVEL_BIT];
    src_high[tlic_pkg::SRC_UART] = irq_priority_reg[tlic_pkg::UART_BIT];
    src_high[tlic_pkg::SRC_TIMER2] = irq_priority_reg[tlic_pkg::TIMER2_BIT];
    src_high[tlic_pkg::SRC_INTERVAL] = secondary_enable_priority_reg[tlic_pkg::INTERVAL_LEVEL_BIT];
  end

  // each source lands in one of the two level vectors, or in neither when masked
  for (genvar s = 0; s < tlic_pkg::NUM_SRC; s++) begin : g_split
    assign req_high[s] = raw_req[s] && src_on[s] && src_high[s];
    assign req_low[s] = raw_req[s] && src_on[s] && !src_high[s];
  end

  //------------------------------------------------------------
  // level arbitration
  //------------------------------------------------------------
  logic found_high;
  logic found_low;
  logic [3:0] index_high;
  logic [3:0] index_low;
  logic active_high;
  logic active_low;
  logic take_high;
  logic take_low;
  logic high_free;
  logic low_free;

  tlic_poll u_poll_high (
    .req_i(req_high),
    .found_o(found_high),
    .index_o(index_high)
  );

  tlic_poll u_poll_low (
    .req_i(req_low),
    .found_o(found_low),
    .index_o(index_low)
  );

  // a level is free only while no routine of that level or above runs
  assign high_free = !active_high;
  assign low_free = !active_high && !active_low;
  // high preempts low, same level never preempts
  assign take_high = found_high && high_free;
  // low taken only when no high request competes
  assign take_low = found_low && !found_high && low_free;

  function automatic logic [15:0] vector_of(input logic [3:0] idx);
    logic [15:0] v;
    v = tlic_pkg::VEC_EXT0;
    unique case (idx)
      4'(tlic_pkg::SRC_SUPPLY): v = tlic_pkg::VEC_SUPPLY;
      4'(tlic_pkg::SRC_WDOG): v = tlic_pkg::VEC_WDOG;
      4'(tlic_pkg::SRC_EXT0): v = tlic_pkg::VEC_EXT0;
      4'(tlic_pkg::SRC_ADC): v = tlic_pkg::VEC_ADC;
      4'(tlic_pkg::SRC_TIMER0): v = tlic_pkg::VEC_TIMER0;
      4'(tlic_pkg::SRC_EXT1): v = tlic_pkg::VEC_EXT1;
      4'(tlic_pkg::SRC_TIMER1): v = tlic_pkg::VEC_TIMER1;
      4'(tlic_pkg::SRC_SPI): v = tlic_pkg::VEC_SPI;
      4'(tlic_pkg::SRC_UART): v = tlic_pkg::VEC_UART;
      4'(tlic_pkg::SRC_TIMER2): v = tlic_pkg::VEC_TIMER2;
      4'(tlic_pkg::SRC_INTERVAL): v = tlic_pkg::VEC_INTERVAL;
      default: v = tlic_pkg::VEC_EXT0;
    endcase
    return v;
  endfunction : vector_of

  //------------------------------------------------------------
  // acceptance sequence
  //------------------------------------------------------------
  tlic_pkg::tlic_state_e state;
  logic [3:0] grant_src;
  logic grant_high;
  logic accept;
  logic [3:0] next_grant_src;

  // a request is taken only from idle, so one vector is in flight at a time
  assign accept = (state == tlic_pkg::TLIC_IDLE) && core_ready_i && (take_high || take_low);
  assign next_grant_src = take_high ? index_high : index_low;

  // the grant is frozen at acceptance; later flag changes cannot redirect a vector in flight
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      grant_src <= 4'h0;
      grant_high <= 1'b0;
    end else if (accept) begin
      grant_src <= next_grant_src;
      grant_high <= take_high;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= tlic_pkg::TLIC_IDLE;
    end else begin
      unique case (state)
        tlic_pkg::TLIC_IDLE: begin
          if (accept) begin
            state <= tlic_pkg::TLIC_SAVE;
          end
        end
        // wait for the core to save the program counter
        tlic_pkg::TLIC_SAVE: begin
          if (pc_saved_i) begin
            state <= tlic_pkg::TLIC_VECTOR;
          end
        end
        tlic_pkg::TLIC_VECTOR: begin
          state <= tlic_pkg::TLIC_IDLE;
        end
        default: begin
          state <= tlic_pkg::TLIC_IDLE;
        end
      endcase
    end
  end

  // active levels set on vector, released on return
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      active_high <= 1'b0;
      active_low <= 1'b0;
    end else if (state == tlic_pkg::TLIC_VECTOR) begin
      if (grant_high) begin
        active_high <= 1'b1;
      end else begin
        active_low <= 1'b1;
      end
    end else if (reti_i) begin
      // the innermost routine returns first, so release high before low
      if (active_high) begin
        active_high <= 1'b0;
      end else begin
        active_low <= 1'b0;
      end
    end
  end

  // vector_o and src_o hold between grants, so a late reader still sees the last one
  // vector registered from the frozen grant
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      vector_o <= 16'h0000;
      src_o <= 4'h0;
    end else if (state == tlic_pkg::TLIC_SAVE && pc_saved_i) begin
      vector_o <= vector_of(grant_src);
      src_o <= grant_src;
    end
  end

  // handshake outputs are decoded straight from the state and the request vectors
  assign irq_req_o = take_high || take_low;
  assign pc_save_o = (state == tlic_pkg::TLIC_SAVE);
  assign vector_valid_o = (state == tlic_pkg::TLIC_VECTOR);
  assign active_high_o = active_high;
  assign active_low_o = active_low;
endmodule : tlic_top

// file: dv/tlic_chk.sv
// port-level assertion checker for the interrupt controller
`timescale 1ns/10ps
module tlic_chk (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic pc_saved_i,
  input wire logic reti_i,
  input wire logic irq_req_o,
  input wire logic pc_save_o,
  input wire logic vector_valid_o,
  input wire logic [15:0] vector_o,
  input wire logic [3:0] src_o,
  input wire logic active_high_o,
  input wire logic active_low_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);
  //------------------------------------------------------------
  // handshake and priority relations
  //------------------------------------------------------------
  save_first_a : assert property
    (vector_valid_o |-> $past(pc_save_o && pc_saved_i)) else $error("vector without saved pc");
  save_next_a : assert property
    (pc_save_o && pc_saved_i |=> vector_valid_o) else $error("vector late after pc save");
  save_hold_a : assert property
    (pc_save_o && !pc_saved_i |=> pc_save_o && !vector_valid_o) else $error("pc save dropped early");
  wdog_vector_a : assert property
    (vector_valid_o && src_o == 4'h1 |-> vector_o == 16'h005B) else $error("watchdog vector wrong");
  wdog_high_a : assert property
    (vector_valid_o && src_o == 4'h1 |=> active_high_o) else $error("watchdog not high level");
  high_block_a : assert property
    (active_high_o |-> !irq_req_o) else $error("request during high routine");
  low_hold_a : assert property
    (active_low_o && !reti_i |=> active_low_o) else $error("low level lost without return");
  high_release_a : assert property
    (reti_i && active_high_o |=> !active_high_o && active_low_o == $past(active_low_o))
    else $error("return released wrong level");
endmodule : tlic_chk

bind tlic_top tlic_chk u_chk (.clock_i(clock_i), .rstn_i(rstn_i), .pc_saved_i(pc_saved_i), .reti_i(reti_i),
  .irq_req_o(irq_req_o), .pc_save_o(pc_save_o), .vector_valid_o(vector_valid_o), .vector_o(vector_o),
  .src_o(src_o), .active_high_o(active_high_o), .active_low_o(active_low_o));

// file: dv/tlic_core_model.sv
// behavioural core that answers program counter save requests
`timescale 1ns/10ps
module tlic_core_model (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic pc_save_i,
  input wire logic [1:0] delay_i,
  output logic pc_saved_o
);
  logic [1:0] wait_cnt;
  // push pc first
  // a settable delay mimics a slow stack push
  always @(negedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_cnt <= 2'h0;
      pc_saved_o <= 1'b0;
    end else if (pc_save_i && wait_cnt == delay_i) begin
      pc_saved_o <= 1'b1;
    end else begin
      pc_saved_o <= 1'b0;
      wait_cnt <= pc_save_i ? wait_cnt + 2'h1 : 2'h0;
    end
  end
endmodule : tlic_core_model

// file: dv/two_level_interrupt_controller_tb.sv
// self-checking bench for the two level interrupt controller
`timescale 1ns/10ps
module two_level_interrupt_controller_tb;
  logic clock_i, rstn_i, wr, rd, rdy, reti, wd_sel, saved, hit, irq, psave, vv, act_h, act_l;
  logic [7:0] addr, wdata, rdata;
  logic [15:0] vec;
  logic [3:0] src, wd_to;
  logic [1:0] dly;
  logic [13:0] fl;
  int n_fail = 0;
  int cmp_count = 0;
  logic [15:0] exp_vec [14] = '{16'h0043, 16'h005B, 16'h0003, 16'h0033, 16'h0033, 16'h000B, 16'h0013,
    16'h001B, 16'h003B, 16'h0023, 16'h0023, 16'h002B, 16'h002B, 16'h0053};
  logic [3:0] exp_src [14] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h8, 4'h9,
    4'h9, 4'hA};
  tlic_top dut (.clock_i(clock_i), .rstn_i(rstn_i), .sfr_addr_i(addr), .sfr_wdata_i(wdata), .sfr_wr_i(wr),
    .sfr_rd_i(rd), .sfr_rdata_o(rdata), .sfr_hit_o(hit), .supply_mon_flag_i(fl[0]), .watchdog_flag_i(fl[1]),
    .watchdog_irq_select_i(wd_sel), .watchdog_timeout_i(wd_to), .ext0_flag_i(fl[2]), .adc_done_a_i(fl[3]),
    .adc_done_b_i(fl[4]), .timer0_overflow_i(fl[5]), .ext1_flag_i(fl[6]), .timer1_overflow_i(fl[7]),
    .spi_done_flag_i(fl[8]), .rx_done_flag_i(fl[9]), .tx_done_flag_i(fl[10]), .timer2_overflow_i(fl[11]),
    .timer2_ext_flag_i(fl[12]), .interval_flag_i(fl[13]), .core_ready_i(rdy), .pc_saved_i(saved),
    .reti_i(reti), .irq_req_o(irq), .pc_save_o(psave), .vector_valid_o(vv), .vector_o(vec), .src_o(src),
    .active_high_o(act_h), .active_low_o(act_l));
  tlic_core_model core (.clock_i(clock_i), .rstn_i(rstn_i), .pc_save_i(psave), .delay_i(dly),
    .pc_saved_o(saved));
  //------------------------------------------------------------
  // access tasks
  //------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    {addr, wdata, wr} = {a, d, 1'b1};
    @(negedge clock_i);
    wr = 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] d, input logic h);
    @(negedge clock_i);
    {addr, rd} = {a, 1'b1};
    @(negedge clock_i);
    rd = 1'b0;
    chk(16'(rdata), 16'(d));
    chk(16'(hit), 16'(h));
  endtask : rd_reg
  // irq is combinational, so a short settle is enough
  task automatic see_irq(input logic e);
    repeat (3) @(negedge clock_i);
    chk(16'(irq), 16'(e));
  endtask : see_irq
  task automatic svc(input logic [15:0] v, input logic [3:0] s);
    int n;
    n = 0;
    rdy = 1'b1;
    @(negedge clock_i);
    while (vv !== 1'b1) begin
      n++;
      if (n > 20) begin
        n_fail++;
        wrap_up();
      end
      @(negedge clock_i);
    end
    rdy = 1'b0;
    chk(vec, v);
    chk(16'(src), 16'(s));
  endtask : svc
  task automatic ret;
    @(negedge clock_i);
    reti = 1'b1;
    @(negedge clock_i);
    reti = 1'b0;
  endtask : ret
  //------------------------------------------------------------
  // clock and sequence
  //------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  initial begin
    {rstn_i, wr, rd, rdy, reti, wd_sel} = 6'h00;
    {addr, wdata, wd_to, dly, fl} = 36'h0;
    repeat (2) @(negedge clock_i);
    rstn_i = 1'b1;
    rd_reg(8'hA8, 8'h00, 1'b1);
    rd_reg(8'hA9, 8'hA0, 1'b1);
    rd_reg(8'hB8, 8'h00, 1'b1);
    rd_reg(8'hC0, 8'h00, 1'b0);
    wr_reg(8'hB8, 8'hFF);
    rd_reg(8'hB8, 8'h7F, 1'b1);
    wr_reg(8'hA9, 8'h77);
    rd_reg(8'hA9, 8'hF7, 1'b1);
    wr_reg(8'hB8, 8'h00);
    wr_reg(8'hA9, 8'h07);
    wr_reg(8'hA8, 8'h01);
    fl[2] = 1'b1;
    see_irq(1'b0);
    wr_reg(8'hA8, 8'h81);
    see_irq(1'b1);
    wr_reg(8'hA8, 8'h80);
    see_irq(1'b0);
    // every flag but the watchdog pending at once, served in polling order by a slow core
    wr_reg(8'hA8, 8'hFF);
    {fl, dly} = {14'h3FFD, 2'h2};
    for (int i = 0; i < 14; i++) begin
      if (i != 1) begin
        svc(exp_vec[i], exp_src[i]);
        fl[i] = 1'b0;
        ret();
      end
    end
    dly = 2'h0;
    wr_reg(8'hB8, 8'h02);
    wr_reg(8'hA9, 8'h47);
    fl[2] = 1'b1;
    svc(16'h0003, 4'h2);
    fl[6] = 1'b1;
    see_irq(1'b0);
    chk(16'(act_l), 16'h0001);
    fl[5] = 1'b1;
    svc(16'h000B, 4'h4);
    fl[13] = 1'b1;
    see_irq(1'b0);
    fl[5] = 1'b0;
    ret();
    chk(16'({act_h, act_l}), 16'h0001);
    svc(16'h0053, 4'hA);
    fl = 14'h0;
    ret();
    ret();
    fl = 14'h2004;
    svc(16'h0053, 4'hA);
    fl[13] = 1'b0;
    ret();
    svc(16'h0003, 4'h2);
    fl = 14'h0;
    ret();
    wr_reg(8'hA8, 8'h00);
    {fl[1], wd_to} = 5'h15;
    see_irq(1'b0);
    {wd_sel, wd_to} = 5'h10;
    see_irq(1'b0);
    wd_to = 4'h5;
    see_irq(1'b1);
    dly = 2'h3;
    svc(16'h005B, 4'h1);
    @(negedge clock_i);
    chk(16'(act_h), 16'h0001);
    fl = 14'h0;
    ret();
    wrap_up();
  end
endmodule : two_level_interrupt_controller_tb
